// file: cad_exec_unit.sv
// Top of the integer execution datapath: ALU, flags, multiplier, divider, shifter.
`timescale 1ns/10ps
`default_nettype none

module cad_exec_unit (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              op_start,
    input  wire cad_pkg::cad_op_t  op_code,
    input  wire logic              byte_mode,
    input  wire logic              src_mem,
    input  wire logic              dst_mem,
    input  wire logic [15:0]       reg_a,
    input  wire logic [15:0]       reg_b,
    input  wire logic [15:0]       mem_rdata,
    input  wire logic              shift_multi,
    input  wire logic [3:0]        shift_amt,
    input  wire cad_pkg::cad_mul_t mul_mode,
    input  wire logic [4:0]        mul_lit,
    input  wire logic              div_signed,
    input  wire logic              div_long,
    input  wire logic [15:0]       div_lo,
    input  wire logic [15:0]       div_hi,
    input  wire logic [15:0]       div_divisor,
    output logic      [15:0]       res_q,
    output logic                   res_byte_q,
    output logic                   reg_wr_q,
    output logic                   mem_wr_q,
    output logic      [4:0]        flag_register_q,
    output logic      [31:0]       prod_q,
    output logic                   prod_wr_q,
    output logic      [15:0]       quotient_reg_q,
    output logic      [15:0]       remainder_reg_q,
    output logic                   div_wr_q,
    output logic                   busy_q,
    output logic                   done_q
);

    logic              go;
    logic              is_shift;
    logic              is_arith;
    logic              is_logic;
    logic              alu_op;
    logic              multi;
    logic              to_mem;
    logic [15:0]       opnd_a;
    logic [15:0]       b_eff;
    logic              is_sub;
    logic [16:0]       sum17;
    logic [15:0]       cin_x;
    logic              add_c;
    logic              add_wrap;
    logic [15:0]       alu_y;
    logic [15:0]       sh_val;
    logic [3:0]        sh_amt;
    cad_pkg::cad_shk_t sh_kind;
    logic [15:0]       sh_y;
    logic              sh_c;
    logic [15:0]       mul_a;
    logic [15:0]       mul_b;
    logic              mul_sa;
    logic              mul_sb;
    logic [33:0]       mul_p;
    logic [31:0]       dvd;
    logic              div_last;

    // Request acceptance and operation classes; requests are ignored while dividing.
    always_comb begin
        go       = op_start & ~busy_q;
        is_shift = (op_code == cad_pkg::OP_UP) | (op_code == cad_pkg::OP_SIGN_RIGHT)
                 | (op_code == cad_pkg::OP_ZERO_RIGHT);
        is_arith = (op_code == cad_pkg::OP_ADD) | (op_code == cad_pkg::OP_SUB);
        is_logic = (op_code == cad_pkg::OP_AND) | (op_code == cad_pkg::OP_IOR)
                 | (op_code == cad_pkg::OP_XOR);
        alu_op   = is_shift | is_arith | is_logic;
        multi    = is_shift & shift_multi;
        to_mem   = dst_mem & ~multi;
    end

    // First operand source: memory only when the addressing mode asks and no multi-bit shift.
    always_comb begin
        opnd_a = (src_mem && !multi) ? mem_rdata : reg_a;
    end

    // Two's complement adder; subtract adds the inverted operand plus one.
    always_comb begin
        is_sub   = (op_code == cad_pkg::OP_SUB);
        b_eff    = is_sub ? ~reg_b : reg_b;
        sum17    = {1'h0, opnd_a} + {1'h0, b_eff} + {16'h0000, is_sub};
        cin_x    = opnd_a ^ b_eff ^ sum17[15:0];
        add_c    = byte_mode ? cin_x[cad_pkg::CRY_BYTE_BIT] : sum17[cad_pkg::W];
        add_wrap = (cad_pkg::top_bit(opnd_a, byte_mode) == cad_pkg::top_bit(b_eff, byte_mode))
                 & (cad_pkg::top_bit(sum17[15:0], byte_mode)
                    != cad_pkg::top_bit(opnd_a, byte_mode));
    end

    // Shifter operand preparation; byte width sign- or zero-extends the low byte.
    always_comb begin
        sh_amt = shift_multi ? shift_amt : cad_pkg::SH_ONE;
        unique case (op_code)
            cad_pkg::OP_SIGN_RIGHT: sh_kind = cad_pkg::SHK_SIGN;
            cad_pkg::OP_ZERO_RIGHT: sh_kind = cad_pkg::SHK_ZERO;
            default:                sh_kind = cad_pkg::SHK_UP;
        endcase
        if (!byte_mode) begin
            sh_val = opnd_a;
        end else if (sh_kind == cad_pkg::SHK_SIGN) begin
            sh_val = {{cad_pkg::BYTE_W{opnd_a[cad_pkg::BYTE_W-1]}}, opnd_a[7:0]};
        end else begin
            sh_val = cad_pkg::fit(opnd_a, 1'h1);
        end
    end

    cad_shifter u_shifter (
        .val       (sh_val),
        .amt       (sh_amt),
        .kind      (sh_kind),
        .byte_mode (byte_mode),
        .y         (sh_y),
        .cout      (sh_c)
    );

    // Result selection among adder, logic and shifter.
    always_comb begin
        unique case (op_code)
            cad_pkg::OP_ADD, cad_pkg::OP_SUB: alu_y = sum17[15:0];
            cad_pkg::OP_AND:                  alu_y = opnd_a & reg_b;
            cad_pkg::OP_IOR:                  alu_y = opnd_a | reg_b;
            cad_pkg::OP_XOR:                  alu_y = opnd_a ^ reg_b;
            default:                          alu_y = sh_y;
        endcase
    end

    // Multiplier operand forming and 17 by 17 signed product.
    always_comb begin
        mul_a  = opnd_a;
        mul_b  = reg_b;
        mul_sa = 1'h0;
        mul_sb = 1'h0;
        unique case (mul_mode)
            cad_pkg::MUL_SS: begin
                mul_sa = 1'h1;
                mul_sb = 1'h1;
            end
            cad_pkg::MUL_UU: begin
                mul_sa = 1'h0;
            end
            cad_pkg::MUL_US: begin
                mul_sb = 1'h1;
            end
            cad_pkg::MUL_SU: begin
                mul_sa = 1'h1;
            end
            cad_pkg::MUL_S_LIT: begin
                mul_sa = 1'h1;
                mul_b  = {11'h000, mul_lit};
            end
            cad_pkg::MUL_U_LIT: begin
                mul_b  = {11'h000, mul_lit};
            end
            default: begin
                mul_a  = cad_pkg::fit(opnd_a, 1'h1);
                mul_b  = cad_pkg::fit(reg_b, 1'h1);
            end
        endcase
        mul_p = 34'($signed(cad_pkg::ext17(mul_a, mul_sa)))
              * 34'($signed(cad_pkg::ext17(mul_b, mul_sb)));
    end

    // Dividend: odd register of the pair is the upper half; short forms are extended.
    always_comb begin
        if (div_long) begin
            dvd = {div_hi, div_lo};
        end else begin
            dvd = {{cad_pkg::W{div_signed & div_lo[cad_pkg::W-1]}}, div_lo};
        end
    end

    cad_divider u_divider (
        .clk       (clk),
        .rstn      (rstn),
        .start     (go && op_code == cad_pkg::OP_DIV),
        .is_signed (div_signed),
        .dividend  (dvd),
        .divisor   (div_divisor),
        .busy_q    (busy_q),
        .last      (div_last),
        .wr_q      (div_wr_q),
        .quot_q    (quotient_reg_q),
        .rem_q     (remainder_reg_q)
    );

    // ALU result register, trimmed to the selected width.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            res_q      <= cad_pkg::RES_RST;
            res_byte_q <= 1'h0;
        end else if (go && alu_op) begin
            res_q      <= cad_pkg::fit(alu_y, byte_mode);
            res_byte_q <= byte_mode;
        end
    end

    // Destination strobes for the result.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_wr_q <= 1'h0;
            mem_wr_q <= 1'h0;
        end else begin
            reg_wr_q <= go & alu_op & ~to_mem;
            mem_wr_q <= go & alu_op & to_mem;
        end
    end

    // Flag register update by operation class.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_register_q <= cad_pkg::FLAG_RST;
        end else if (go && alu_op) begin
            flag_register_q[cad_pkg::FLG_Z]   <= (cad_pkg::fit(alu_y, byte_mode)
                                                  == cad_pkg::RES_RST);
            flag_register_q[cad_pkg::FLG_NEG] <= cad_pkg::top_bit(alu_y, byte_mode);
            if (is_arith) begin
                flag_register_q[cad_pkg::FLG_C]    <= add_c;
                flag_register_q[cad_pkg::FLG_NIB]  <= cin_x[cad_pkg::NIB_BIT];
                flag_register_q[cad_pkg::FLG_WRAP] <= add_wrap;
            end else if (is_shift) begin
                flag_register_q[cad_pkg::FLG_C]    <= sh_c;
            end
        end
    end

    // Product register and its write strobe.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prod_q    <= cad_pkg::PROD_RST;
            prod_wr_q <= 1'h0;
        end else begin
            prod_wr_q <= go & (op_code == cad_pkg::OP_MUL);
            if (go && op_code == cad_pkg::OP_MUL) begin
                prod_q <= mul_p[31:0];
            end
        end
    end

    // Completion pulse; a divide completes only on its final iteration.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done_q <= 1'h0;
        end else begin
            done_q <= (go & (op_code != cad_pkg::OP_DIV)) | div_last;
        end
    end

    a_add_word: assert property (@(posedge clk) disable iff (!rstn)
        (go && op_code == cad_pkg::OP_ADD && !byte_mode)
        |=> res_q == 16'($past(opnd_a) + $past(reg_b)))
        else $error("Word add result wrong.");

    a_zero_flag: assert property (@(posedge clk) disable iff (!rstn)
        (go && alu_op) |=> flag_register_q[cad_pkg::FLG_Z] == (res_q == 16'h0000))
        else $error("Zero flag disagrees with result.");

    a_sub_borrow: assert property (@(posedge clk) disable iff (!rstn)
        (go && is_sub && !byte_mode)
        |=> flag_register_q[cad_pkg::FLG_C] == ($past(opnd_a) >= $past(reg_b)))
        else $error("Subtract borrow flag wrong.");

    a_byte_width: assert property (@(posedge clk) disable iff (!rstn)
        (go && alu_op && byte_mode) |=> res_q[15:8] == 8'h00 && res_byte_q)
        else $error("Byte result has upper bits set.");

    a_mem_source: assert property (@(posedge clk) disable iff (!rstn)
        (go && op_code == cad_pkg::OP_IOR && src_mem && !byte_mode)
        |=> res_q == ($past(mem_rdata) | $past(reg_b)))
        else $error("Memory operand not used.");

    a_dest_mem: assert property (@(posedge clk) disable iff (!rstn)
        (go && is_arith && dst_mem) |=> mem_wr_q && !reg_wr_q)
        else $error("Memory destination not honoured.");

    a_mul_unsigned: assert property (@(posedge clk) disable iff (!rstn)
        (go && op_code == cad_pkg::OP_MUL && mul_mode == cad_pkg::MUL_UU)
        |=> prod_wr_q && prod_q == {16'h0000, $past(opnd_a)} * {16'h0000, $past(reg_b)})
        else $error("Unsigned product wrong.");

    a_mul_signed: assert property (@(posedge clk) disable iff (!rstn)
        (go && op_code == cad_pkg::OP_MUL && mul_mode == cad_pkg::MUL_SS)
        |=> $signed(prod_q) == $signed($past(opnd_a)) * $signed($past(reg_b)))
        else $error("Signed product wrong.");

    a_div_latency: assert property (@(posedge clk) disable iff (!rstn)
        (go && op_code == cad_pkg::OP_DIV)
        |=> (busy_q && !div_wr_q) [*8] ##1 (busy_q && !div_wr_q) [*8]
            ##1 (div_wr_q && done_q && !busy_q))
        else $error("Divide did not finish after sixteen iterations.");

    a_sign_shift: assert property (@(posedge clk) disable iff (!rstn)
        (go && op_code == cad_pkg::OP_SIGN_RIGHT && shift_multi && !byte_mode)
        |=> res_q == 16'($signed($past(opnd_a)) >>> $past(shift_amt)))
        else $error("Sign-fill shift wrong.");

    a_multi_reg: assert property (@(posedge clk) disable iff (!rstn)
        (go && multi) |=> reg_wr_q && !mem_wr_q)
        else $error("Multi-bit shift left the register file.");

endmodule

`default_nettype wire

// file: cad_pkg.sv
// Shared constants, types and helper functions for the integer execution datapath.
package cad_pkg;

    // Datapath widths.
    localparam int W        = 16;
    localparam int BYTE_W   = 8;
    localparam int SHAMT_W  = 4;
    localparam int CNT_W    = 5;

    // Bit positions used for carry extraction.
    localparam int CRY_BYTE_BIT = 8;
    localparam int NIB_BIT      = 4;

    // Flag register layout.
    localparam int FLG_C    = 0;
    localparam int FLG_Z    = 1;
    localparam int FLG_WRAP = 2;
    localparam int FLG_NEG  = 3;
    localparam int FLG_NIB  = 4;
    localparam int FLG_W    = 5;

    // Reset values and fixed counts.
    localparam logic [15:0]        RES_RST   = 16'h0000;
    localparam logic [31:0]        PROD_RST  = 32'h0000_0000;
    localparam logic [4:0]         FLAG_RST  = 5'h00;
    localparam logic [15:0]        BYTE_MASK = 16'h00FF;
    localparam logic [SHAMT_W-1:0] SH_ONE    = 4'h1;
    localparam logic [CNT_W-1:0]   DIV_ITER  = 5'h10;
    localparam logic [CNT_W-1:0]   CNT_LAST  = 5'h01;
    localparam logic [CNT_W-1:0]   CNT_RST   = 5'h00;

    // Operation codes presented by the instruction decoder.
    typedef enum logic [3:0] {
        OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR,
        OP_UP, OP_SIGN_RIGHT, OP_ZERO_RIGHT, OP_MUL, OP_DIV
    } cad_op_t;

    // Multiplier operand modes: signedness of first and second operand.
    typedef enum logic [2:0] {
        MUL_SS, MUL_UU, MUL_US, MUL_SU, MUL_S_LIT, MUL_U_LIT, MUL_BYTE
    } cad_mul_t;

    // Shifter direction and fill kind.
    typedef enum logic [1:0] {
        SHK_UP, SHK_SIGN, SHK_ZERO
    } cad_shk_t;

    // Most significant bit of the selected operand width.
    function automatic logic top_bit(input logic [15:0] v, input logic bm);
        return bm ? v[BYTE_W-1] : v[W-1];
    endfunction

    // Clears the upper byte of a value when the byte width is selected.
    function automatic logic [15:0] fit(input logic [15:0] v, input logic bm);
        return bm ? (v & BYTE_MASK) : v;
    endfunction

    // Extends a word to 17 bits as signed or unsigned.
    function automatic logic signed [16:0] ext17(input logic [15:0] v, input logic sg);
        return {sg & v[W-1], v};
    endfunction

endpackage

// file: cad_shifter.sv
// Single-cycle barrel shifter for left, sign-fill right and zero-fill right shifts.
`timescale 1ns/10ps
`default_nettype none

module cad_shifter (
    input  wire logic [15:0]     val,
    input  wire logic [3:0]      amt,
    input  wire cad_pkg::cad_shk_t kind,
    input  wire logic            byte_mode,
    output logic      [15:0]     y,
    output logic                 cout
);

    logic [31:0] up_x;
    logic [17:0] rt_x;
    logic        fill;

    // Shift by up to fifteen places in one pass; the last bit out goes to carry.
    always_comb begin
        up_x = {16'h0000, val} << amt;
        fill = (kind == cad_pkg::SHK_SIGN) & val[cad_pkg::W-1];
        rt_x = 18'($signed({fill, val, 1'h0}) >>> amt);
        if (kind == cad_pkg::SHK_UP) begin
            y    = up_x[15:0];
            cout = byte_mode ? up_x[cad_pkg::CRY_BYTE_BIT] : up_x[cad_pkg::W];
        end else begin
            y    = rt_x[16:1];
            cout = rt_x[0];
        end
    end

endmodule

`default_nettype wire

// file: cad_divider.sv
// Iterative restoring divider, one quotient bit per clock, 32/16 and 16/16.
`timescale 1ns/10ps
`default_nettype none

module cad_divider (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic        is_signed,
    input  wire logic [31:0] dividend,
    input  wire logic [15:0] divisor,
    output logic             busy_q,
    output logic             last,
    output logic             wr_q,
    output logic      [15:0] quot_q,
    output logic      [15:0] rem_q
);

    logic [4:0]  cnt_q;
    logic [16:0] part_q;
    logic [15:0] low_q;
    logic [15:0] dvs_q;
    logic        nq_q;
    logic        nr_q;
    logic [16:0] shifted;
    logic [17:0] trial;
    logic [16:0] part_d;
    logic [15:0] low_d;
    logic [31:0] mag_dvd;
    logic [15:0] mag_dvs;
    logic [31:0] chk_dvd_q;
    logic [15:0] chk_dvs_q;
    logic        chk_sgn_q;

    // One restoring step: shift in the next dividend bit and try to subtract.
    always_comb begin
        shifted = {part_q[15:0], low_q[15]};
        trial   = {1'h0, shifted} - {2'h0, dvs_q};
        part_d  = trial[17] ? shifted : trial[16:0];
        low_d   = {low_q[14:0], ~trial[17]};
        mag_dvd = (is_signed & dividend[31]) ? -dividend : dividend;
        mag_dvs = (is_signed & divisor[15]) ? -divisor : divisor;
        last    = busy_q & (cnt_q == cad_pkg::CNT_LAST);
    end

    // Sequencing: load magnitudes, iterate sixteen times, then finish.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_q <= 1'h0;
            cnt_q  <= cad_pkg::CNT_RST;
            part_q <= 17'h00000;
            low_q  <= cad_pkg::RES_RST;
            dvs_q  <= cad_pkg::RES_RST;
            nq_q   <= 1'h0;
            nr_q   <= 1'h0;
        end else if (start && !busy_q) begin
            busy_q <= 1'h1;
            cnt_q  <= cad_pkg::DIV_ITER;
            part_q <= {1'h0, mag_dvd[31:16]};
            low_q  <= mag_dvd[15:0];
            dvs_q  <= mag_dvs;
            nq_q   <= is_signed & (dividend[31] ^ divisor[15]);
            nr_q   <= is_signed & dividend[31];
        end else if (busy_q) begin
            part_q <= part_d;
            low_q  <= low_d;
            cnt_q  <= cnt_q - cad_pkg::CNT_LAST;
            busy_q <= !last;
        end
    end

    // Sign correction and the write of quotient and remainder.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_q   <= 1'h0;
            quot_q <= cad_pkg::RES_RST;
            rem_q  <= cad_pkg::RES_RST;
        end else begin
            wr_q <= last;
            if (last) begin
                quot_q <= nq_q ? -low_d : low_d;
                rem_q  <= nr_q ? -part_d[15:0] : part_d[15:0];
            end
        end
    end

    // Operands kept only for checking the finished result.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chk_dvd_q <= cad_pkg::PROD_RST;
            chk_dvs_q <= cad_pkg::RES_RST;
            chk_sgn_q <= 1'h0;
        end else if (start && !busy_q) begin
            chk_dvd_q <= dividend;
            chk_dvs_q <= divisor;
            chk_sgn_q <= is_signed;
        end
    end

    a_div_unsigned_ok: assert property (@(posedge clk) disable iff (!rstn)
        (wr_q && !chk_sgn_q && chk_dvs_q != 16'h0000 && chk_dvd_q[31:16] < chk_dvs_q)
        |-> ({16'h0000, quot_q} * {16'h0000, chk_dvs_q} + {16'h0000, rem_q} == chk_dvd_q)
            && (rem_q < chk_dvs_q))
        else $error("Unsigned divide result does not match the operands.");

    a_div_signed_rem: assert property (@(posedge clk) disable iff (!rstn)
        (wr_q && chk_sgn_q && rem_q != 16'h0000) |-> (rem_q[15] == chk_dvd_q[31]))
        else $error("Signed remainder does not carry the dividend sign.");

endmodule

`default_nettype wire

// file: cad_mem_model.sv
// Behavioural data memory that supplies operands and takes results.
`timescale 1ns/10ps
`default_nettype none
module cad_mem_model (
    input  wire logic        clk,
    input  wire logic [2:0]  addr,
    input  wire logic        ld,
    input  wire logic [15:0] ld_data,
    input  wire logic        wr,
    input  wire logic [15:0] wdata,
    output logic      [15:0] rdata
);
    logic [15:0] mem_q [16];
    // Results land in the upper half, so a late write never races a read.
    always_ff @(posedge clk) begin
        if (ld) begin
            mem_q[{1'b0, addr}] <= ld_data;
        end else if (wr) begin
            mem_q[{1'b1, addr}] <= wdata;
        end
    end
    assign rdata = mem_q[{1'b0, addr}];
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the execution datapath with a memory partner.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk, rstn, op_start, byte_mode, src_mem, dst_mem, shift_multi, m, sa, sb;
    logic        div_signed, div_long, res_byte_q, reg_wr_q, mem_wr_q, prod_wr_q;
    logic        div_wr_q, busy_q, done_q, ld;
    logic [2:0]  maddr;
    logic [3:0]  shift_amt;
    logic [4:0]  mul_lit, flag_register_q, fl;
    logic [15:0] reg_a, reg_b, mem_rdata, div_lo, div_hi, div_divisor, res_q, r, av, bv;
    logic [15:0] quotient_reg_q, remainder_reg_q, ld_data, shadow [8];
    logic [31:0] prod_q, seed = 32'h0000CFB4, cyc = 32'h0;
    logic [63:0] ex, sv, exp_q [$];
    int          mismatches = 0, checked = 0;
    logic signed [33:0] p;
    logic signed [32:0] dd, dv;
    cad_pkg::cad_op_t  op_code;
    cad_pkg::cad_mul_t mul_mode;
    cad_exec_unit dut (
        .clk(clk), .rstn(rstn), .op_start(op_start), .op_code(op_code), .byte_mode(byte_mode),
        .src_mem(src_mem), .dst_mem(dst_mem), .reg_a(reg_a), .reg_b(reg_b),
        .mem_rdata(mem_rdata), .shift_multi(shift_multi), .shift_amt(shift_amt),
        .mul_mode(mul_mode), .mul_lit(mul_lit), .div_signed(div_signed), .div_long(div_long),
        .div_lo(div_lo), .div_hi(div_hi), .div_divisor(div_divisor), .res_q(res_q),
        .res_byte_q(res_byte_q), .reg_wr_q(reg_wr_q), .mem_wr_q(mem_wr_q),
        .flag_register_q(flag_register_q), .prod_q(prod_q), .prod_wr_q(prod_wr_q),
        .quotient_reg_q(quotient_reg_q), .remainder_reg_q(remainder_reg_q),
        .div_wr_q(div_wr_q), .busy_q(busy_q), .done_q(done_q));
    cad_mem_model mem (.clk(clk), .addr(maddr), .ld(ld), .ld_data(ld_data),
                       .wr(mem_wr_q), .wdata(res_q), .rdata(mem_rdata));
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    // Reference result of an ALU or shift operation at the chosen width.
    function automatic logic [15:0] alu(input logic [2:0] c, input logic [15:0] a, b,
                                        input logic bm, input logic [3:0] n);
        logic [15:0] y;
        case (c)
            3'h0: y = a + b;
            3'h1: y = a - b;
            3'h2: y = a & b;
            3'h3: y = a | b;
            3'h4: y = a ^ b;
            3'h5: y = a << n;
            3'h6: begin
                y = $signed(a) >>> n;
                if (bm) begin
                    y = {8'h00, 8'($signed(a[7:0]) >>> n)};
                end
            end
            default: y = bm ? a[7:0] >> n : a >> n;
        endcase
        return bm ? y & 16'h00FF : y;
    endfunction
    // Reference flags: Z and N always, carry, nibble and wrap on add and subtract, carry on shifts.
    function automatic logic [4:0] flg(input logic [2:0] c, input logic [15:0] a, b, y,
                                       input logic bm, input logic [3:0] n, input logic [4:0] f);
        logic [16:0] s;
        logic [15:0] e;
        logic [4:0]  r;
        r = f;
        r[cad_pkg::FLG_Z] = y == 16'h0000;
        r[cad_pkg::FLG_NEG] = bm ? y[7] : y[15];
        e = c[0] ? ~b : b;
        if (c < 3'h2) begin
            s = bm ? 17'(a[7:0]) + 17'(e[7:0]) + 17'(c[0]) : 17'(a) + 17'(e) + 17'(c[0]);
            r[cad_pkg::FLG_C] = bm ? s[8] : s[16];
            s = 17'(a[3:0]) + 17'(e[3:0]) + 17'(c[0]);
            r[cad_pkg::FLG_NIB] = s[4];
            r[cad_pkg::FLG_WRAP] = bm ? (a[7] == e[7]) && (y[7] != a[7])
                                      : (a[15] == e[15]) && (y[15] != a[15]);
        end else if (c > 3'h4) begin
            e = !bm ? a : (c == 3'h6) ? {{8{a[7]}}, a[7:0]} : {8'h00, a[7:0]};
            s = {1'b0, e} << n;
            r[cad_pkg::FLG_C] = c == 3'h5 ? (bm ? s[8] : s[16]) : n != 4'h0 && e[n - 4'h1];
        end
        return r;
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        checked++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED at %0t: result differs", $time);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic go(input cad_pkg::cad_op_t c, input logic [63:0] e);
        op_code = c;
        op_start = 1'b1;
        exp_q.push_back(e);
        @(negedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 32'h1;
    // Takes the oldest note whenever a result strobe shows and compares.
    always @(negedge clk) begin
        if (reg_wr_q || mem_wr_q || prod_wr_q || div_wr_q) begin
            ex = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            if (prod_wr_q) begin
                check({32'h0, prod_q}, ex);
            end else if (div_wr_q) begin
                sv = {cyc[29:0], busy_q, done_q, quotient_reg_q, remainder_reg_q};
                check(sv, ex);
            end else begin
                sv = {40'h0, done_q, mem_wr_q, res_byte_q, flag_register_q, res_q};
                check(sv, ex);
            end
        end
    end
    // Cuts a hang short well after the expected run length.
    initial begin
        repeat (2000) @(posedge clk);
        mismatches++;
        close_out();
    end
    initial begin
        {rstn, op_start, byte_mode, src_mem, dst_mem, shift_multi, div_signed, div_long, ld} = '0;
        {maddr, shift_amt, mul_lit, reg_a, reg_b, div_lo, div_hi, div_divisor, ld_data} = '0;
        op_code = cad_pkg::OP_ADD;
        mul_mode = cad_pkg::MUL_SS;
        fl = 5'h00;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        ld = 1'b1;
        for (int i = 0; i < 8; i++) begin
            maddr = 3'(i);
            ld_data = rnd();
            shadow[i] = ld_data;
            @(negedge clk);
        end
        ld = 1'b0;
        repeat (200) begin
            r = rnd();
            {byte_mode, src_mem, dst_mem, shift_multi, shift_amt, maddr} = r[10:0];
            reg_a = rnd();
            reg_b = rnd();
            m = shift_multi && r[15:13] > 3'h4;
            bv = (src_mem && !m) ? shadow[maddr] : reg_a;
            av = alu(r[15:13], bv, reg_b, byte_mode, shift_multi ? shift_amt : 4'h1);
            fl = flg(r[15:13], bv, reg_b, av, byte_mode, shift_multi ? shift_amt : 4'h1, fl);
            go(cad_pkg::cad_op_t'({1'b0, r[15:13]}),
               {40'h0, 1'b1, dst_mem && !m, byte_mode, fl, av});
        end
        $display("alu test done");
        {src_mem, dst_mem} = 2'h0;
        for (int i = 0; i < 28; i++) begin
            mul_mode = cad_pkg::cad_mul_t'(3'(i % 7));
            reg_a = rnd();
            reg_b = rnd();
            mul_lit = 5'(rnd());
            sa = i % 7 inside {0, 3, 4};
            sb = i % 7 inside {0, 2};
            av = i % 7 == 6 ? {8'h00, reg_a[7:0]} : reg_a;
            bv = i % 7 == 6 ? {8'h00, reg_b[7:0]} : (i % 7 > 3 ? {11'h000, mul_lit} : reg_b);
            p = $signed({sa & av[15], av}) * $signed({sb & bv[15], bv});
            go(cad_pkg::OP_MUL, {32'h0, p[31:0]});
        end
        $display("mul test done");
        for (int i = 0; i < 8; i++) begin
            {div_signed, div_long} = 2'(i);
            r = rnd();
            div_lo = rnd();
            div_hi = div_signed ? {16{div_lo[15]}} : {8'h00, r[7:0]};
            div_divisor = (r & 16'hFFFE) | 16'h0102;
            dd = div_long ? {div_signed & div_hi[15], div_hi, div_lo}
                          : {{17{div_signed & div_lo[15]}}, div_lo};
            dv = {{17{div_signed & div_divisor[15]}}, div_divisor};
            go(cad_pkg::OP_DIV, {30'(cyc + 32'h11), 2'h1, 16'(dd / dv), 16'(dd % dv)});
            op_code = cad_pkg::OP_ADD;
            repeat (16) @(negedge clk);
        end
        op_start = 1'b0;
        repeat (4) @(negedge clk);
        $display("div test done");
        check(64'(exp_q.size()), 64'h0);
        close_out();
    end
endmodule
`default_nettype wire
